// ### idm_pkg.sv
// Constants, field layout and message carrier for the destination match block.
// Assumes one 20 MHz clock domain; peers share a message bus on the same clock.
//
// Operation
// - Legacy level bit set: issue as edge
// - Level bit zero only for init-deassert
// - Physical new: 00-FE single, FF all
// - Physical legacy: 0-0E single, 0F all
// - Logical: compare address with logical, format
// - Logical register holds 8-bit logical id
// - Format register 4-bit model field
// - Model 1111 selects flat
// - Flat: accept when address AND id nonzero
// - Flat: all-ones address is broadcast
// - Model 0000 selects cluster
// - Cluster: upper nibble matches cluster id
// - Cluster: lower nibble selects members by bit
// - Clusters 0-14, four members each
// - Cluster: all-ones address selects everyone
// - Format register resets to flat
// - Shorthand ignores destination mode and field
// - Self shorthand: issuer sole destination
// - Low command word write sends message
package idm_pkg;
  // Register byte offsets
  localparam logic [4:0] OFS_ICR_LO = 5'h00;
  localparam logic [4:0] OFS_ICR_HI = 5'h04;
  localparam logic [4:0] OFS_LDR    = 5'h08;
  localparam logic [4:0] OFS_DFR    = 5'h0C;
  localparam logic [4:0] OFS_ID     = 5'h10;
  localparam logic [4:0] OFS_CFG    = 5'h14;
  localparam logic [4:0] OFS_STAT   = 5'h18;
  // Command word and register field positions
  localparam int ICR_DLV_LSB   = 8;
  localparam int ICR_DMODE_BIT = 11;
  localparam int ICR_LEVEL_BIT = 14;
  localparam int ICR_TRIG_BIT  = 15;
  localparam int ICR_SH_LSB    = 18;
  localparam int ICR_DEST_LSB  = 24;
  localparam int LDR_ID_LSB    = 24;
  localparam int DFR_MODEL_LSB = 28;
  localparam int STAT_ACC_LSB  = 8;
  localparam int STAT_DISC_LSB = 16;
  // Reset values and encodings
  localparam logic [3:0] MODEL_FLAT    = 4'hF;
  localparam logic [3:0] MODEL_CLUSTER = 4'h0;
  localparam logic [2:0] DLV_INIT      = 3'h5;
  localparam logic [7:0] BCAST_NEW     = 8'hFF;
  localparam logic [3:0] BCAST_OLD     = 4'hF;
  localparam logic [1:0] RESP_OK       = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;
  // Destination shorthand codes
  typedef enum logic [1:0] {
    SH_NONE    = 2'b00,
    SH_SELF    = 2'b01,
    SH_ALL_INC = 2'b10,
    SH_ALL_EXC = 2'b11
  } idm_sh_t;
  // Message on the shared interrupt bus
  typedef struct packed {
    logic [7:0] src;
    logic [7:0] dest;
    idm_sh_t    sh;
    logic       dmode;
    logic       trig;
    logic       level;
    logic       deassert;
    logic [2:0] dlv;
    logic [7:0] vec;
  } idm_msg_t;
endpackage : idm_pkg

// ### idm_dest_match.sv
// Inter-processor message builder and destination matcher for one controller.
// Registers: command word halves, logical id, format model, own id, a legacy
// bus select and a status word with counts and the illegal level flag.
// Assumes an Avalon-MM master on i_clk and a message bus driven on the same clock.
//
// Decided for this implementation: the register addresses and the Avalon-MM slave port.
`timescale 1ns/10ps
module idm_dest_match
  import idm_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Avalon-MM slave
  input  wire logic [4:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic      [1:0]  o_avs_response,
  output logic             o_avs_waitrequest,
  // Outgoing message
  output logic             o_tx_valid,
  output idm_msg_t         o_tx_msg,
  // Incoming message from the shared bus
  input  wire logic        i_rx_valid,
  input  wire idm_msg_t    i_rx_msg,
  // Match result
  output logic             o_acc_valid,
  output idm_msg_t         o_acc_msg,
  output logic             o_disc_valid
);

  // Byte-lane write mask
  // Partial writes merge by lane, so software can touch one field alone
  logic [31:0] wmask;
  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++) begin : g_lane
      assign wmask[8*gb +: 8] = {8{i_avs_byteenable[gb]}};
    end
  endgenerate

  // Bus handshake state
  logic        wait_r,   wait_nxt;     // Waitrequest, high while idle
  logic [31:0] rdata_r,  rdata_nxt;    // Read data, loaded one cycle early
  logic [1:0]  resp_r,   resp_nxt;     // Response code
  // Register file
  logic [31:0] icr_lo_r, icr_lo_nxt;   // Low command word
  logic [7:0]  dest_r,   dest_nxt;     // High command word destination byte
  logic [7:0]  lid_r,    lid_nxt;      // Logical id field
  logic [3:0]  model_r,  model_nxt;    // Format model nibble
  logic [7:0]  pid_r,    pid_nxt;      // Own physical id
  logic        legacy_r, legacy_nxt;   // Older four-bit bus implementation
  logic        err_r,    err_nxt;      // Sticky illegal level bit
  logic [7:0]  nacc_r,   nacc_nxt;     // Accepted message count
  logic [7:0]  ndis_r,   ndis_nxt;     // Discarded message count
  // Message paths
  logic        tx_v_r,   tx_v_nxt;
  idm_msg_t    tx_m_r,   tx_m_nxt;
  logic        acc_v_r,  acc_v_nxt;
  idm_msg_t    acc_m_r,  acc_m_nxt;
  logic        dis_v_r,  dis_v_nxt;
  // Decoded helpers
  logic        req;                    // Request pending
  logic        take;                   // Edge where the request completes
  logic        wr_lo;                  // Accepted low command word write
  logic [31:0] merged;                 // Write data merged over old value
  logic        hit;                    // Incoming message matches
  logic [31:0] cur;                    // Current value at the address

  // Waitrequest idles high so every request sees one wait cycle;
  // the answer is registered in it and the bus outputs stay flop-driven
  assign req   = i_avs_read | i_avs_write;
  assign take  = req & ~wait_r;
  assign wr_lo = take & i_avs_write & (i_avs_address == OFS_ICR_LO);

  // Current value and mapped check for the addressed register
  // Unmapped places read zero and answer with an error response
  always_comb begin
    cur = 32'h0000_0000;
    unique case (i_avs_address)
      OFS_ICR_LO: cur = icr_lo_r;
      OFS_ICR_HI: cur = {dest_r, 24'h00_0000};
      OFS_LDR:    cur = {lid_r, 24'h00_0000};
      OFS_DFR:    cur = {model_r, 28'h000_0000};
      OFS_ID:     cur = {24'h00_0000, pid_r};
      OFS_CFG:    cur = {31'h0, legacy_r};
      OFS_STAT:   cur = {8'h00, ndis_r, nacc_r, 7'h00, err_r};
      default:    cur = 32'h0000_0000;
    endcase
    merged = (cur & ~wmask) | (i_avs_writedata & wmask);
  end

  // Destination compare for an incoming message
  // Hit is worked out every cycle but only used with the valid strobe
  always_comb begin
    hit = 1'b0;
    unique case (i_rx_msg.sh)
      // Shorthands ignore mode and destination field
      SH_SELF:    hit = (i_rx_msg.src == pid_r);
      SH_ALL_INC: hit = 1'b1;
      SH_ALL_EXC: hit = (i_rx_msg.src != pid_r);
      SH_NONE: begin
        if (!i_rx_msg.dmode) begin
          // Physical: legacy compares four bits only
          if (legacy_r) begin
            hit = (i_rx_msg.dest[3:0] == BCAST_OLD) ||
                  (i_rx_msg.dest[3:0] == pid_r[3:0]);
          end else begin
            hit = (i_rx_msg.dest == BCAST_NEW) ||
                  (i_rx_msg.dest == pid_r);
          end
        end else if (model_r == MODEL_FLAT) begin
          // Flat: one bit per controller; all ones reaches even a zero id
          hit = (i_rx_msg.dest == BCAST_NEW) ||
                |(i_rx_msg.dest & lid_r);
        end else if (model_r == MODEL_CLUSTER) begin
          // Cluster 0-14 by nibble, members by bit; all ones hits all
          hit = (i_rx_msg.dest == BCAST_NEW) ||
                ((i_rx_msg.dest[7:4] == lid_r[7:4]) &&
                 |(i_rx_msg.dest[3:0] & lid_r[3:0]));
        end else begin
          // Unprogrammed model value never matches
          hit = 1'b0;
        end
      end
    endcase
  end

  // Next values for bus, registers and message paths
  always_comb begin
    wait_nxt   = ~(req & wait_r);
    rdata_nxt  = rdata_r;
    resp_nxt   = resp_r;
    icr_lo_nxt = icr_lo_r;
    dest_nxt   = dest_r;
    lid_nxt    = lid_r;
    model_nxt  = model_r;
    pid_nxt    = pid_r;
    legacy_nxt = legacy_r;
    err_nxt    = err_r;
    nacc_nxt   = nacc_r;
    ndis_nxt   = ndis_r;
    tx_v_nxt   = 1'b0;
    tx_m_nxt   = tx_m_r;
    acc_v_nxt  = 1'b0;
    acc_m_nxt  = acc_m_r;
    dis_v_nxt  = 1'b0;
    // Answer is prepared in the first request cycle
    // Reading the status word never clears it; writing a one to bit 0 clears the level flag only
    if (req && wait_r) begin
      rdata_nxt = i_avs_read ? cur : 32'h0000_0000;
      unique case (i_avs_address)
        OFS_ICR_LO, OFS_ICR_HI, OFS_LDR, OFS_DFR,
        OFS_ID, OFS_CFG, OFS_STAT: resp_nxt = RESP_OK;
        default:                   resp_nxt = RESP_SLVERR;
      endcase
    end
    // Writes land at the completing edge only
    if (take && i_avs_write) begin
      unique case (i_avs_address)
        OFS_ICR_LO: icr_lo_nxt = merged;
        OFS_ICR_HI: dest_nxt   = merged[ICR_DEST_LSB +: 8];
        OFS_LDR:    lid_nxt    = merged[LDR_ID_LSB +: 8];
        OFS_DFR:    model_nxt  = merged[DFR_MODEL_LSB +: 4];
        OFS_ID:     pid_nxt    = merged[7:0];
        OFS_CFG:    legacy_nxt = merged[0];
        OFS_STAT:   err_nxt    = err_r & ~(i_avs_writedata[0] & i_avs_byteenable[0]);
        default:    err_nxt    = err_r;
      endcase
    end
    // Build and send on a low command word write
    // Destination comes from the high word, so software writes that first
    if (wr_lo) begin
      tx_m_nxt.src   = pid_r;
      tx_m_nxt.vec   = merged[7:0];
      tx_m_nxt.dlv   = merged[ICR_DLV_LSB +: 3];
      tx_m_nxt.dmode = merged[ICR_DMODE_BIT];
      tx_m_nxt.level = merged[ICR_LEVEL_BIT];
      tx_m_nxt.sh    = idm_sh_t'(merged[ICR_SH_LSB +: 2]);
      // Level bit set forces edge delivery
      tx_m_nxt.trig  = merged[ICR_TRIG_BIT] & ~merged[ICR_LEVEL_BIT];
      tx_m_nxt.deassert = ~merged[ICR_LEVEL_BIT];
      // Shorthands carry a broadcast field, all-excluding goes physical
      if (tx_m_nxt.sh == SH_NONE) begin
        tx_m_nxt.dest = dest_r;
      end else if (legacy_r) begin
        tx_m_nxt.dest = {4'h0, BCAST_OLD};
      end else begin
        tx_m_nxt.dest = BCAST_NEW;
      end
      if (tx_m_nxt.sh == SH_ALL_EXC) begin
        tx_m_nxt.dmode = 1'b0;
      end
      // Level bit zero is legal only as init deassert
      if (!merged[ICR_LEVEL_BIT] && merged[ICR_DLV_LSB +: 3] != DLV_INIT) begin
        err_nxt = 1'b1;
      end else begin
        tx_v_nxt = 1'b1;
      end
    end
    // Incoming message: accept or drop, drop touches nothing else
    // Counters wrap at 8 bits; they show activity and steer nothing
    if (i_rx_valid) begin
      if (hit) begin
        acc_v_nxt = 1'b1;
        acc_m_nxt = i_rx_msg;
        nacc_nxt  = nacc_r + 8'h01;
      end else begin
        dis_v_nxt = 1'b1;
        ndis_nxt  = ndis_r + 8'h01;
      end
    end
  end

  // Register every group; format model resets to flat
  // Synchronous reset only, and every reset value is a constant
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wait_r   <= 1'b1;
      rdata_r  <= 32'h0000_0000;
      resp_r   <= RESP_OK;
      icr_lo_r <= 32'h0000_0000;
      dest_r   <= 8'h00;
      lid_r    <= 8'h00;
      model_r  <= MODEL_FLAT;
      pid_r    <= 8'h00;
      legacy_r <= 1'b0;
      err_r    <= 1'b0;
      nacc_r   <= 8'h00;
      ndis_r   <= 8'h00;
      tx_v_r   <= 1'b0;
      tx_m_r   <= '0;
      acc_v_r  <= 1'b0;
      acc_m_r  <= '0;
      dis_v_r  <= 1'b0;
    end else begin
      wait_r   <= wait_nxt;
      rdata_r  <= rdata_nxt;
      resp_r   <= resp_nxt;
      icr_lo_r <= icr_lo_nxt;
      dest_r   <= dest_nxt;
      lid_r    <= lid_nxt;
      model_r  <= model_nxt;
      pid_r    <= pid_nxt;
      legacy_r <= legacy_nxt;
      err_r    <= err_nxt;
      nacc_r   <= nacc_nxt;
      ndis_r   <= ndis_nxt;
      tx_v_r   <= tx_v_nxt;
      tx_m_r   <= tx_m_nxt;
      acc_v_r  <= acc_v_nxt;
      acc_m_r  <= acc_m_nxt;
      dis_v_r  <= dis_v_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign o_avs_waitrequest = wait_r;
  assign o_avs_readdata    = rdata_r;
  assign o_avs_response    = resp_r;
  assign o_tx_valid        = tx_v_r;
  assign o_tx_msg          = tx_m_r;
  assign o_acc_valid       = acc_v_r;
  assign o_acc_msg         = acc_m_r;
  assign o_disc_valid      = dis_v_r;

  // Checks on the delivered behaviour
  chk_flat_and_hit: assert property (@(posedge i_clk) disable iff (i_rst)
    i_rx_valid && i_rx_msg.sh == SH_NONE && i_rx_msg.dmode &&
    model_r == MODEL_FLAT && |(i_rx_msg.dest & lid_r) |=> o_acc_valid)
    else $error("flat match not accepted");
  chk_cluster_bcast: assert property (@(posedge i_clk) disable iff (i_rst)
    i_rx_valid && i_rx_msg.sh == SH_NONE && i_rx_msg.dmode &&
    model_r == MODEL_CLUSTER && i_rx_msg.dest == BCAST_NEW |=> o_acc_valid)
    else $error("cluster broadcast not accepted");
  chk_phys_new_id: assert property (@(posedge i_clk) disable iff (i_rst)
    i_rx_valid && i_rx_msg.sh == SH_NONE && !i_rx_msg.dmode && !legacy_r &&
    i_rx_msg.dest != pid_r && i_rx_msg.dest != BCAST_NEW |=> o_disc_valid)
    else $error("physical mismatch accepted");
  chk_phys_old_bcast: assert property (@(posedge i_clk) disable iff (i_rst)
    i_rx_valid && i_rx_msg.sh == SH_NONE && !i_rx_msg.dmode && legacy_r &&
    i_rx_msg.dest[3:0] == BCAST_OLD |=> o_acc_valid)
    else $error("legacy broadcast not accepted");
  chk_drop_no_state: assert property (@(posedge i_clk) disable iff (i_rst)
    o_disc_valid |-> !o_acc_valid && $stable(o_acc_msg) && nacc_r == $past(nacc_r))
    else $error("discard changed accept state");
  chk_format_reset: assert property (@(posedge i_clk)
    $past(i_rst) |-> model_r == MODEL_FLAT)
    else $error("format not flat after reset");
  chk_level_edge: assert property (@(posedge i_clk) disable iff (i_rst)
    o_tx_valid && o_tx_msg.level |-> !o_tx_msg.trig)
    else $error("level message not sent as edge");
  chk_level_zero: assert property (@(posedge i_clk) disable iff (i_rst)
    o_tx_valid && !o_tx_msg.level |-> o_tx_msg.dlv == DLV_INIT && o_tx_msg.deassert)
    else $error("level zero on non-init message");
  chk_send_on_low: assert property (@(posedge i_clk) disable iff (i_rst)
    o_tx_valid |-> $past(wr_lo))
    else $error("message sent without low word write");
  chk_self_only: assert property (@(posedge i_clk) disable iff (i_rst)
    o_acc_valid && o_acc_msg.sh == SH_SELF |-> o_acc_msg.src == pid_r)
    else $error("self message accepted by other");

  // Receive side: every incoming message gets exactly one verdict
  chk_one_outcome: assert property (@(posedge i_clk) disable iff (i_rst)
    i_rx_valid |=> o_acc_valid != o_disc_valid)
    else $error("message without single verdict");
  chk_idle_quiet: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_rx_valid |=> !o_acc_valid && !o_disc_valid)
    else $error("verdict without message");
  // Physical compares, both bus generations
  chk_phys_new_hit: assert property (@(posedge i_clk) disable iff (i_rst)
    i_rx_valid && i_rx_msg.sh == SH_NONE && !i_rx_msg.dmode && !legacy_r &&
    (i_rx_msg.dest == pid_r || i_rx_msg.dest == BCAST_NEW) |=> o_acc_valid)
    else $error("physical match not accepted");
  chk_phys_old_id: assert property (@(posedge i_clk) disable iff (i_rst)
    i_rx_valid && i_rx_msg.sh == SH_NONE && !i_rx_msg.dmode && legacy_r &&
    i_rx_msg.dest[3:0] == pid_r[3:0] |=> o_acc_valid)
    else $error("legacy physical match not accepted");
  chk_phys_old_miss: assert property (@(posedge i_clk) disable iff (i_rst)
    i_rx_valid && i_rx_msg.sh == SH_NONE && !i_rx_msg.dmode && legacy_r &&
    i_rx_msg.dest[3:0] != pid_r[3:0] && i_rx_msg.dest[3:0] != BCAST_OLD |=> o_disc_valid)
    else $error("legacy physical mismatch accepted");
  // Logical compares, flat, cluster and unknown models
  chk_flat_bcast: assert property (@(posedge i_clk) disable iff (i_rst)
    i_rx_valid && i_rx_msg.sh == SH_NONE && i_rx_msg.dmode &&
    model_r == MODEL_FLAT && i_rx_msg.dest == BCAST_NEW |=> o_acc_valid)
    else $error("flat broadcast not accepted");
  chk_flat_miss: assert property (@(posedge i_clk) disable iff (i_rst)
    i_rx_valid && i_rx_msg.sh == SH_NONE && i_rx_msg.dmode && model_r == MODEL_FLAT &&
    i_rx_msg.dest != BCAST_NEW && (i_rx_msg.dest & lid_r) == 8'h00 |=> o_disc_valid)
    else $error("flat mismatch accepted");
  chk_cluster_member: assert property (@(posedge i_clk) disable iff (i_rst)
    i_rx_valid && i_rx_msg.sh == SH_NONE && i_rx_msg.dmode && model_r == MODEL_CLUSTER &&
    i_rx_msg.dest[7:4] == lid_r[7:4] && |(i_rx_msg.dest[3:0] & lid_r[3:0]) |=> o_acc_valid)
    else $error("cluster member not accepted");
  chk_cluster_other: assert property (@(posedge i_clk) disable iff (i_rst)
    i_rx_valid && i_rx_msg.sh == SH_NONE && i_rx_msg.dmode && model_r == MODEL_CLUSTER &&
    i_rx_msg.dest != BCAST_NEW && i_rx_msg.dest[7:4] != lid_r[7:4] |=> o_disc_valid)
    else $error("other cluster accepted");
  chk_cluster_nomember: assert property (@(posedge i_clk) disable iff (i_rst)
    i_rx_valid && i_rx_msg.sh == SH_NONE && i_rx_msg.dmode && model_r == MODEL_CLUSTER &&
    i_rx_msg.dest != BCAST_NEW && (i_rx_msg.dest[3:0] & lid_r[3:0]) == 4'h0 |=> o_disc_valid)
    else $error("unselected member accepted");
  chk_model_other: assert property (@(posedge i_clk) disable iff (i_rst)
    i_rx_valid && i_rx_msg.sh == SH_NONE && i_rx_msg.dmode &&
    model_r != MODEL_FLAT && model_r != MODEL_CLUSTER |=> o_disc_valid)
    else $error("unknown model accepted");
  // Shorthands decide on the source alone
  chk_short_all_inc: assert property (@(posedge i_clk) disable iff (i_rst)
    i_rx_valid && i_rx_msg.sh == SH_ALL_INC |=> o_acc_valid)
    else $error("all-including message dropped");
  chk_short_exc_self: assert property (@(posedge i_clk) disable iff (i_rst)
    i_rx_valid && i_rx_msg.sh == SH_ALL_EXC && i_rx_msg.src == pid_r |=> o_disc_valid)
    else $error("all-excluding message taken by issuer");
  chk_self_other: assert property (@(posedge i_clk) disable iff (i_rst)
    i_rx_valid && i_rx_msg.sh == SH_SELF && i_rx_msg.src != pid_r |=> o_disc_valid)
    else $error("self message taken by other");
  // Send side: message fields and the illegal level flag
  chk_short_dest: assert property (@(posedge i_clk) disable iff (i_rst)
    o_tx_valid && o_tx_msg.sh != SH_NONE |->
    o_tx_msg.dest == (legacy_r ? {4'h0, BCAST_OLD} : BCAST_NEW))
    else $error("shorthand send without broadcast field");
  chk_exc_physical: assert property (@(posedge i_clk) disable iff (i_rst)
    o_tx_valid && o_tx_msg.sh == SH_ALL_EXC |-> !o_tx_msg.dmode)
    else $error("all-excluding send not physical");
  chk_err_set: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_lo && !merged[ICR_LEVEL_BIT] && merged[ICR_DLV_LSB +: 3] != DLV_INIT |=>
    err_r && !o_tx_valid)
    else $error("illegal level send not refused");
  chk_err_sticky: assert property (@(posedge i_clk) disable iff (i_rst)
    err_r && !(take && i_avs_write && i_avs_address == OFS_STAT) |=> err_r)
    else $error("illegal level flag lost");

endmodule : idm_dest_match

// ### idm_peer_model.sv
// Peer controller model standing on the shared interrupt message bus.
// Assumes one clock shared with the block and the bench's synchronous reset.
`timescale 1ns/10ps
module idm_peer_model
  import idm_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // Message that the peer itself sends
  input  wire logic       i_send,
  input  wire idm_msg_t   i_msg,
  // Message that the block puts on the bus
  input  wire logic       i_tx_valid,
  input  wire idm_msg_t   i_tx_msg,
  // Shared bus towards the block
  output logic            o_bus_valid,
  output idm_msg_t        o_bus_msg,
  // Observed sends of the block
  output logic      [7:0] o_tx_cnt,
  output idm_msg_t        o_tx_last
);
  // Bus register; the block's own sends are looped back like any snooped message
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_bus_valid <= 1'b0;
      o_bus_msg   <= '0;
      o_tx_cnt    <= 8'h00;
      o_tx_last   <= '0;
    end else begin
      o_bus_valid <= i_send | i_tx_valid;
      if (i_tx_valid) begin // Snoop back the block's send
        o_bus_msg <= i_tx_msg;
        o_tx_cnt  <= o_tx_cnt + 8'h01;
        o_tx_last <= i_tx_msg;
      end else if (i_send) begin // Peer message goes out unchanged
        o_bus_msg <= i_msg;
      end else begin // Released bus toggles so stale data never looks valid
        o_bus_msg <= ~o_bus_msg;
      end
    end
  end
endmodule : idm_peer_model

// ### idm_dest_match_tb.sv
// Self-checking bench for the destination match block.
// Assumes the peer model drives the shared bus and loops back the block's sends.
`timescale 1ns/10ps
module idm_dest_match_tb import idm_pkg::*;;
  // Bench signals
  logic        i_clk, i_rst, i_avs_read, i_avs_write, i_send;
  logic [4:0]  i_avs_address;
  logic [31:0] i_avs_writedata, o_avs_readdata, q;
  logic [1:0]  o_avs_response, last_resp;
  logic        o_avs_waitrequest, o_tx_valid, rx_valid, o_acc_valid, o_disc_valid;
  idm_msg_t    o_tx_msg, rx_msg, o_acc_msg, s_msg, tx_last, m, e;
  logic [7:0]  tx_cnt;
  logic [51:0] r;
  int          error_cnt, tests_run;
  // Rows: id, legacy, model, logical id, shorthand, dmode, src, dest, accept
  logic [51:0] rows [24] = '{
    52'h05_0F_00_00_01_05_1, 52'h05_0F_00_00_01_06_0, 52'h05_0F_00_00_01_FF_1,
    52'hFE_0F_00_00_01_FE_1, 52'h05_0F_00_00_01_0F_0, 52'h0E_1F_00_00_01_0E_1,
    52'h03_1F_00_00_01_0F_1, 52'h0E_1F_00_00_01_1E_1, 52'h0E_1F_00_00_01_03_0,
    52'h05_0F_24_01_01_04_1, 52'h05_0F_2A_01_01_05_0, 52'h05_0F_2A_01_01_FF_1,
    52'h05_00_32_01_01_32_1, 52'h05_00_32_01_01_3D_0, 52'h05_00_32_01_01_42_0,
    52'h05_00_32_01_01_FF_1, 52'h05_00_E1_01_01_E9_1, 52'h05_05_FF_01_01_FF_0,
    52'h05_0F_00_10_05_33_1, 52'h05_0F_00_10_06_05_0, 52'h05_0F_00_21_01_00_1,
    52'h05_0F_00_30_05_05_0, 52'h05_0F_00_31_01_00_1, 52'h05_0F_00_01_01_FF_1};

  // Block under test; byte lanes always full words
  idm_dest_match DUT (.i_clk(i_clk), .i_rst(i_rst), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(4'hF), .o_avs_readdata(o_avs_readdata),
    .o_avs_response(o_avs_response), .o_avs_waitrequest(o_avs_waitrequest),
    .o_tx_valid(o_tx_valid), .o_tx_msg(o_tx_msg), .i_rx_valid(rx_valid), .i_rx_msg(rx_msg),
    .o_acc_valid(o_acc_valid), .o_acc_msg(o_acc_msg), .o_disc_valid(o_disc_valid));

  // Peer on the shared bus
  idm_peer_model PEER (.i_clk(i_clk), .i_rst(i_rst), .i_send(i_send), .i_msg(s_msg),
    .i_tx_valid(o_tx_valid), .i_tx_msg(o_tx_msg), .o_bus_valid(rx_valid),
    .o_bus_msg(rx_msg), .o_tx_cnt(tx_cnt), .o_tx_last(tx_last));

  // 20 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  // Compare and count
  task automatic cmp(input logic [39:0] got, input logic [39:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t ns: %s", $time, what);
    end
  endtask : cmp

  // One Avalon cycle; holds until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    int n;
    n = 0;
    i_avs_address   <= a;
    i_avs_writedata <= d;
    i_avs_write     <= wr;
    i_avs_read      <= ~wr;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 40);
    if (n >= 40) cmp(40'h1, 40'h0, "bus stuck");
    rd = o_avs_readdata;
    last_resp = o_avs_response;
    i_avs_write <= 1'b0;
    i_avs_read  <= 1'b0;
    // Extra edge so back-to-back calls never drive a strobe twice in one step
    @(posedge i_clk);
  endtask : bus

  // Collect accept and discard pulses over a short window
  task automatic watch(input logic exp);
    logic acc, disc;
    acc = 1'b0;
    disc = 1'b0;
    repeat (4) begin
      @(posedge i_clk);
      acc = acc | (o_acc_valid === 1'b1);
      disc = disc | (o_disc_valid === 1'b1);
    end
    cmp({38'h0, acc, disc}, {38'h0, exp, ~exp}, "match outcome");
  endtask : watch

  // Peer sends one message and the outcome is judged
  task automatic send_rx(input idm_msg_t msg, input logic exp);
    s_msg  <= msg;
    i_send <= 1'b1;
    @(posedge i_clk);
    i_send <= 1'b0;
    watch(exp);
    if (exp) cmp(40'(o_acc_msg), 40'(msg), "accepted copy");
  endtask : send_rx

  // Verdict and end of run
  task automatic test_done;
    if (error_cnt == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done

  // Watchdog well beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge i_clk);
    error_cnt++;
    $display("Error %0t ns: timeout", $time);
    test_done;
  end

  // Main sequence
  initial begin
    i_rst = 1'b1;
    i_avs_read = 1'b0;
    i_avs_write = 1'b0;
    i_avs_address = 5'h00;
    i_avs_writedata = 32'h0;
    i_send = 1'b0;
    s_msg = '0;
    error_cnt = 0;
    tests_run = 0;
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_clk);
    // Reset values, register access, unmapped place
    bus(1'b0, OFS_DFR, 32'h0, q);
    cmp(40'(q), 40'hF000_0000, "format reset");
    bus(1'b0, OFS_LDR, 32'h0, q);
    cmp(40'(q), 40'h0, "logical id reset");
    bus(1'b1, OFS_LDR, 32'hA500_0000, q);
    bus(1'b0, OFS_LDR, 32'h0, q);
    cmp(40'(q), 40'hA500_0000, "logical id write");
    bus(1'b0, 5'h1C, 32'h0, q);
    cmp({6'h0, last_resp, q}, {6'h0, RESP_SLVERR, 32'h0}, "unmapped read");
    // Table of destination cases; format set before traffic
    foreach (rows[i]) begin
      r = rows[i];
      bus(1'b1, OFS_ID, {24'h0, r[51:44]}, q);
      bus(1'b1, OFS_CFG, {31'h0, r[40]}, q);
      bus(1'b1, OFS_DFR, {r[39:36], 28'h0}, q);
      bus(1'b1, OFS_LDR, {r[35:28], 24'h0}, q);
      m = '0;
      m.src = r[19:12];
      m.dest = r[11:4];
      m.sh = idm_sh_t'(r[25:24]);
      m.dmode = r[20];
      m.level = 1'b1; // Level set on ordinary messages
      m.vec = 8'(i);
      send_rx(m, r[0]);
    end
    // Send with level and trigger set: goes out edge triggered
    bus(1'b1, OFS_ICR_HI, 32'h0700_0000, q);
    bus(1'b1, OFS_ICR_LO, 32'h0000_C041, q);
    repeat (3) @(posedge i_clk);
    e = '0;
    e.src = 8'h05;
    e.dest = 8'h07;
    e.level = 1'b1;
    e.vec = 8'h41;
    cmp(40'(tx_cnt), 40'h1, "send count");
    cmp(40'(tx_last), 40'(e), "edge send");
    // Init deassert may carry level zero
    bus(1'b1, OFS_ICR_LO, 32'h0000_0541, q);
    repeat (3) @(posedge i_clk);
    e.level = 1'b0;
    e.deassert = 1'b1;
    e.dlv = DLV_INIT;
    cmp(40'(tx_last), 40'(e), "deassert send");
    // Level zero on a fixed message is refused
    bus(1'b1, OFS_ICR_LO, 32'h0000_0041, q);
    repeat (3) @(posedge i_clk);
    cmp(40'(tx_cnt), 40'h2, "refused send");
    bus(1'b0, OFS_STAT, 32'h0, q);
    cmp(40'(q[0]), 40'h1, "illegal level flag");
    cmp(40'(q[23:8]), 40'h0B0F, "accept and discard counts");
    bus(1'b1, OFS_STAT, 32'h1, q);
    bus(1'b0, OFS_STAT, 32'h0, q);
    cmp(40'(q[0]), 40'h0, "illegal level flag clear");
    // Self shorthand comes back to the sender only
    bus(1'b1, OFS_ICR_LO, 32'h0004_4041, q);
    watch(1'b1);
    // All-excluding send goes out physical with a broadcast field
    bus(1'b1, OFS_ICR_LO, 32'h000C_4841, q);
    watch(1'b0);
    e = '0;
    e.src = 8'h05;
    e.dest = BCAST_NEW;
    e.sh = SH_ALL_EXC;
    e.level = 1'b1;
    e.vec = 8'h41;
    cmp(40'(tx_last), 40'(e), "all-excluding send");
    // Second reset in mid-run restores the flat model
    bus(1'b1, OFS_DFR, 32'h0, q);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_clk);
    bus(1'b0, OFS_DFR, 32'h0, q);
    cmp(40'(q), 40'hF000_0000, "format after reset");
    test_done;
  end
endmodule : idm_dest_match_tb
